// ### hw/ipf_pkg.sv
`default_nettype none

package ipf_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_REGS = 6;
    localparam int NUM_SRC = 22;
    localparam int LVL_W = 3;
    localparam int REG_W = 16;
    localparam int DATA_W = 32;
    localparam int SEL_W = 3;
    localparam int SRC_W = 5;
    localparam int MIN_ADDR_W = 5;
    localparam int MAX_ADDR_W = 32;

    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_SET_0 = 8'h00;
    localparam logic [7:0] OFF_SET_1 = 8'h04;
    localparam logic [7:0] OFF_SET_2 = 8'h08;
    localparam logic [7:0] OFF_SET_3 = 8'h0C;
    localparam logic [7:0] OFF_SET_4 = 8'h10;
    localparam logic [7:0] OFF_SET_5 = 8'h14;

    // Implemented bits, index 5 first
    localparam logic [NUM_REGS-1:0][REG_W-1:0] IMPL_MASK = {
        16'h7777, 16'h7077, 16'h0777, 16'h7777, 16'h7777, 16'h7777
    };
    // Every field comes up at level 4
    localparam logic [NUM_REGS-1:0][REG_W-1:0] RESET_VAL = {
        16'h4444, 16'h4044, 16'h0444, 16'h4444, 16'h4444, 16'h4444
    };

    // ------------------------------------------------------------
    // Source table: register and low bit of each level field
    // ------------------------------------------------------------
    // 0 timer_a 1 compare_a 2 capture_a 3 ext_irq_a
    // 4 timer_b 5 compare_b 6 capture_b 7 dma_ch_a_done
    // 8 uart_a_rx 9 spi_a_event 10 spi_a_error 11 timer_c
    // 12 dma_ch_b_done 13 adc_a_done 14 uart_a_tx
    // 15 pin_change 16 i2c_a_master 17 i2c_a_slave
    // 18 capture_h 19 capture_g 20 adc_b_done 21 ext_irq_b
    localparam int SRC_REG [NUM_SRC] = '{
        0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4, 4, 4, 5, 5, 5, 5
    };
    localparam int SRC_LSB [NUM_SRC] = '{
        12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 8, 4, 0, 12, 4, 0, 12, 8, 4, 0
    };

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [LVL_W-1:0] LVL_OFF = 3'h0;
    localparam logic [LVL_W-1:0] LVL_MAX = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [DATA_W-REG_W-1:0] PAD_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        W_IDLE = 2'b01,
        W_RESP = 2'b10
    } ipf_wstate_t;

    typedef struct packed {
        logic valid;
        logic [LVL_W-1:0] level;
        logic [SRC_W-1:0] src;
    } ipf_irq_t;

    typedef struct packed {
        ipf_wstate_t wst;
        logic aw_rdy;
        logic w_rdy;
        logic aw_have;
        logic w_have;
        logic [SEL_W-1:0] wsel;
        logic werr;
        logic [REG_W-1:0] wdata;
        logic [1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [SEL_W-1:0] rsel;
        logic [REG_W-1:0] rdata;
        logic [NUM_REGS-1:0][REG_W-1:0] prio;
        ipf_irq_t irq;
    } ipf_state_t;

    localparam ipf_state_t ST_RESET = '{
        wst: W_IDLE,
        aw_rdy: 1'b1,
        w_rdy: 1'b1,
        ar_rdy: 1'b1,
        prio: RESET_VAL,
        default: '0
    };

endpackage

`default_nettype wire

// ### hw/ipf_bank.sv
// How it works
// R1 - Each source has a 3-bit level field; code 111 gives level 7, the highest.
// R2 - Code 001 gives level 1; codes between map to levels in order.
// R3 - Code 000 disables the source; it never raises a request.
// R4 - Unimplemented bits read zero and ignore writes.
// R5 - Reset loads every field with 100, level 4; fields are read/write.
// R6 - Set 0: timer_a 14-12, compare_a 10-8, capture_a 6-4, ext_irq_a 2-0.
// R7 - Set 1: timer_b 14-12, compare_b 10-8, capture_b 6-4, dma_ch_a 2-0.
// R8 - Set 2: uart_a_rx 14-12, spi event 10-8, spi error 6-4, timer_c 2-0.
// R9 - Set 3: bits 15-11 empty; dma_ch_b 10-8, adc_a 6-4, uart_a_tx 2-0.
// R10 - Set 4: pin_change 14-12, bits 11-7 empty, i2c master 6-4, slave 2-0.
// R11 - Set 5: capture_h 14-12, capture_g 10-8, adc_b 6-4, ext_irq_b 2-0.
// R12 - Levels feed arbitration; highest pending enabled request goes to the core.
`timescale 1ns/100ps
`default_nettype none

module ipf_bank #(
    parameter int ADDR_W = 8
) (
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [ADDR_W-1:0] AWADDR_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    input wire logic [ipf_pkg::DATA_W-1:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    output logic BVALID_O,
    input wire logic BREADY_I,
    output logic [1:0] BRESP_O,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    input wire logic [ADDR_W-1:0] ARADDR_I,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic [ipf_pkg::DATA_W-1:0] RDATA_O,
    output logic [1:0] RRESP_O,
    input wire logic [ipf_pkg::NUM_SRC-1:0] REQ_I,
    output ipf_pkg::ipf_irq_t IRQ_O
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (ADDR_W < ipf_pkg::MIN_ADDR_W || ADDR_W > ipf_pkg::MAX_ADDR_W) begin : g_bad_addr_w
        $error("ADDR_W must lie between 5 and 32");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ipf_pkg::ipf_state_t st_reg;
    ipf_pkg::ipf_state_t st_next;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;
    logic [ADDR_W-3:0] aw_word;
    logic [ADDR_W-3:0] ar_word;
    logic [ipf_pkg::REG_W-1:0] lane_mask;
    logic [ipf_pkg::LVL_W-1:0] best_lvl;
    logic [ipf_pkg::SRC_W-1:0] best_src;
    logic [ipf_pkg::LVL_W-1:0] lvl [ipf_pkg::NUM_SRC];

    assign aw_word = AWADDR_I[ADDR_W-1:2];
    assign ar_word = ARADDR_I[ADDR_W-1:2];

    // ------------------------------------------------------------
    // Level extraction, one field per source
    // ------------------------------------------------------------
    for (genvar g = 0; g < ipf_pkg::NUM_SRC; g++) begin : g_lvl
        // Field code is the level itself
        assign lvl[g] = st_reg.prio[ipf_pkg::SRC_REG[g]][ipf_pkg::SRC_LSB[g] +: ipf_pkg::LVL_W]; // R1 R2 R6 R7 R8 R9 R10 R11
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        aw_take = AWVALID_I && st_reg.aw_rdy;
        w_take = WVALID_I && st_reg.w_rdy;
        ar_take = ARVALID_I && st_reg.ar_rdy;
        do_write = 1'b0;
        lane_mask = '0;
        best_lvl = ipf_pkg::LVL_OFF;
        best_src = '0;

        // Address and data are taken in either order
        if (aw_take) begin
            st_next.aw_have = 1'b1;
            st_next.aw_rdy = 1'b0;
            st_next.wsel = aw_word[ipf_pkg::SEL_W-1:0];
            st_next.werr = (aw_word >= ipf_pkg::NUM_REGS);
        end
        if (w_take) begin
            st_next.w_have = 1'b1;
            st_next.w_rdy = 1'b0;
            st_next.wdata = WDATA_I[ipf_pkg::REG_W-1:0];
            st_next.wstrb = WSTRB_I[1:0];
        end

        case (st_reg.wst)
            ipf_pkg::W_IDLE: begin
                if (st_next.aw_have && st_next.w_have) begin
                    do_write = 1'b1;
                    st_next.aw_have = 1'b0;
                    st_next.w_have = 1'b0;
                    st_next.bvalid = 1'b1;
                    st_next.wst = ipf_pkg::W_RESP;
                    // Unmapped words answer with an error and store nothing
                    if (st_next.werr) begin
                        st_next.bresp = ipf_pkg::RESP_SLVERR;
                    end else begin
                        st_next.bresp = ipf_pkg::RESP_OKAY;
                        // Only strobed lanes and implemented bits change
                        lane_mask = {{8{st_next.wstrb[1]}}, {8{st_next.wstrb[0]}}}
                            & ipf_pkg::IMPL_MASK[st_next.wsel]; // R4
                        st_next.prio[st_next.wsel] = (st_reg.prio[st_next.wsel] & ~lane_mask)
                            | (st_next.wdata & lane_mask); // R4 R5
                    end
                end
            end
            ipf_pkg::W_RESP: begin
                // Both write channels reopen together once the response is taken
                if (BREADY_I) begin
                    st_next.bvalid = 1'b0;
                    st_next.aw_rdy = 1'b1;
                    st_next.w_rdy = 1'b1;
                    st_next.wst = ipf_pkg::W_IDLE;
                end
            end
            default: begin
                st_next.wst = ipf_pkg::W_IDLE;
                st_next.bvalid = 1'b0;
                st_next.aw_have = 1'b0;
                st_next.w_have = 1'b0;
                st_next.aw_rdy = 1'b1;
                st_next.w_rdy = 1'b1;
            end
        endcase

        // Read sees the value held before a write in the same cycle
        // Data is captured at the take edge and stands until RREADY
        if (ar_take) begin
            st_next.ar_rdy = 1'b0;
            st_next.rvalid = 1'b1;
            st_next.rsel = ar_word[ipf_pkg::SEL_W-1:0];
            if (ar_word >= ipf_pkg::NUM_REGS) begin
                st_next.rresp = ipf_pkg::RESP_SLVERR;
                st_next.rdata = '0;
            end else begin
                st_next.rresp = ipf_pkg::RESP_OKAY;
                st_next.rdata = st_reg.prio[ar_word[ipf_pkg::SEL_W-1:0]]
                    & ipf_pkg::IMPL_MASK[ar_word[ipf_pkg::SEL_W-1:0]]; // R4
            end
        end else if (st_reg.rvalid && RREADY_I) begin
            st_next.rvalid = 1'b0;
            st_next.ar_rdy = 1'b1;
        end

        // Highest level wins, lowest index on a tie; level 0 never wins
        for (int i = 0; i < ipf_pkg::NUM_SRC; i++) begin
            if (REQ_I[i] && (lvl[i] > best_lvl)) begin // R3 R12
                best_lvl = lvl[i];
                best_src = ipf_pkg::SRC_W'(i);
            end
        end
        st_next.irq.valid = (best_lvl != ipf_pkg::LVL_OFF); // R3 R12
        st_next.irq.level = best_lvl;
        st_next.irq.src = best_src;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            // Every level field reloads and both channels reopen
            st_reg <= ipf_pkg::ST_RESET; // R5
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign AWREADY_O = st_reg.aw_rdy;
    assign WREADY_O = st_reg.w_rdy;
    assign BVALID_O = st_reg.bvalid;
    assign BRESP_O = st_reg.bresp;
    assign ARREADY_O = st_reg.ar_rdy;
    assign RVALID_O = st_reg.rvalid;
    assign RRESP_O = st_reg.rresp;
    assign RDATA_O = {ipf_pkg::PAD_ZERO, st_reg.rdata}; // R4
    assign IRQ_O = st_reg.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (SYS_RST_I);

    a_reset_levels: assert property ( // R5
        $past(SYS_RST_I) |-> (st_reg.prio == ipf_pkg::RESET_VAL) && !IRQ_O.valid
    ) else $error("levels not at reset value after reset");

    a_top_level: assert property ( // R1
        (REQ_I[0] && lvl[0] == ipf_pkg::LVL_MAX)
        |=> IRQ_O.valid && IRQ_O.level == ipf_pkg::LVL_MAX && IRQ_O.src == 5'h00
    ) else $error("level 7 request not presented");

    a_level_passes: assert property ( // R2
        ($onehot(REQ_I) && REQ_I[5] && lvl[5] != ipf_pkg::LVL_OFF)
        |=> IRQ_O.valid && IRQ_O.src == 5'h05 && IRQ_O.level == $past(lvl[5])
    ) else $error("single request level wrong");

    a_off_silent: assert property ( // R3
        ($onehot(REQ_I) && REQ_I[21] && lvl[21] == ipf_pkg::LVL_OFF) |=> !IRQ_O.valid
    ) else $error("disabled source raised a request");

    a_no_req_idle: assert property ( // R3
        (REQ_I == '0) |=> !IRQ_O.valid ##0 IRQ_O.level == ipf_pkg::LVL_OFF
    ) else $error("request without a source");

    a_highest_wins: assert property ( // R12
        (REQ_I[1] && REQ_I[2] && !REQ_I[0] && REQ_I[21:3] == '0 && lvl[2] > lvl[1])
        |=> IRQ_O.src == 5'h02 && IRQ_O.level == $past(lvl[2])
    ) else $error("lower level request chosen");

    a_unimpl_zero: assert property ( // R4
        RVALID_O |-> RDATA_O[31:16] == '0
            && (RDATA_O[15:0] & ~ipf_pkg::IMPL_MASK[st_reg.rsel]) == '0
    ) else $error("unimplemented bit reads as one");

    for (genvar k = 0; k < ipf_pkg::NUM_REGS; k++) begin : g_chk
        a_write_lands: assert property ( // R6 R7 R8 R9 R10 R11
            (do_write && st_next.wsel == k && !st_next.werr && st_next.wstrb == 2'h3)
            |=> st_reg.prio[k] == ($past(st_next.wdata) & ipf_pkg::IMPL_MASK[k])
        ) else $error("written fields not stored as mapped");

        a_unimpl_stored: assert property ( // R4
            (st_reg.prio[k] & ~ipf_pkg::IMPL_MASK[k]) == '0
        ) else $error("unimplemented bit holds a one");

        a_low_lane_kept: assert property (
            (do_write && st_next.wsel == k && !st_next.werr && !st_next.wstrb[0])
            |=> $stable(st_reg.prio[k][7:0])
        ) else $error("unstrobed low byte changed");

        a_high_lane_kept: assert property (
            (do_write && st_next.wsel == k && !st_next.werr && !st_next.wstrb[1])
            |=> $stable(st_reg.prio[k][15:8])
        ) else $error("unstrobed high byte changed");
    end

    a_bresp_hold: assert property (
        (BVALID_O && !BREADY_I) |=> BVALID_O && $stable(BRESP_O)
    ) else $error("write response dropped before ready");

    a_rdata_hold: assert property (
        (RVALID_O && !RREADY_I) |=> RVALID_O && $stable(RDATA_O) && $stable(RRESP_O)
    ) else $error("read data changed before ready");

    a_unmapped_err: assert property (
        (ar_take && ar_word >= ipf_pkg::NUM_REGS)
        |=> RVALID_O && RRESP_O == ipf_pkg::RESP_SLVERR && RDATA_O == '0
    ) else $error("unmapped read not refused");

    // ------------------------------------------------------------
    // Handshake order: one write and one read in flight
    // ------------------------------------------------------------
    a_reset_ready: assert property (
        $past(SYS_RST_I) |-> AWREADY_O && WREADY_O && ARREADY_O && !BVALID_O && !RVALID_O
    ) else $error("bus not idle after reset");

    a_aw_w_refused: assert property (
        BVALID_O |-> !AWREADY_O && !WREADY_O
    ) else $error("write channel open while response pending");

    a_ar_refused: assert property (
        RVALID_O |-> !ARREADY_O
    ) else $error("read channel open while data pending");

    a_write_answer: assert property (
        (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O) |=> BVALID_O
    ) else $error("write response not raised after both taken");

    a_read_answer: assert property (
        (ARVALID_I && ARREADY_O) |=> RVALID_O
    ) else $error("read data not raised after address taken");

    a_write_release: assert property (
        (BVALID_O && BREADY_I) |=> !BVALID_O && AWREADY_O && WREADY_O
    ) else $error("write channel not reopened after response");

    a_read_release: assert property (
        (RVALID_O && RREADY_I) |=> !RVALID_O && ARREADY_O
    ) else $error("read channel not reopened after data");

    // An unmapped write must leave every stored level alone
    a_unmapped_kept: assert property (
        (do_write && st_next.werr)
        |=> BRESP_O == ipf_pkg::RESP_SLVERR && $stable(st_reg.prio)
    ) else $error("unmapped write changed a level");

    // ------------------------------------------------------------
    // Arbitration result
    // ------------------------------------------------------------
    a_idle_output_zero: assert property ( // R3
        !IRQ_O.valid |-> IRQ_O.level == ipf_pkg::LVL_OFF && IRQ_O.src == '0
    ) else $error("idle output carries a level or source");

    a_valid_has_level: assert property ( // R2 R3
        IRQ_O.valid |-> IRQ_O.level != ipf_pkg::LVL_OFF
    ) else $error("presented request has level zero");

    for (genvar s = 0; s < ipf_pkg::NUM_SRC; s++) begin : g_src_chk
        a_winner_pending: assert property ( // R12
            (IRQ_O.valid && IRQ_O.src == s)
            |-> $past(REQ_I[s]) && IRQ_O.level == $past(lvl[s])
        ) else $error("presented source was not requesting at that level");

        a_no_higher_loser: assert property ( // R12
            (IRQ_O.valid && $past(REQ_I[s])) |-> IRQ_O.level >= $past(lvl[s])
        ) else $error("a higher level request was passed over");

        // Equal levels go to the lower index
        a_tie_low_index: assert property ( // R12
            (IRQ_O.valid && $past(REQ_I[s]) && IRQ_O.src > s)
            |-> IRQ_O.level > $past(lvl[s])
        ) else $error("tie not resolved to the lower index");
    end

    c_write_done: cover property (BVALID_O && BREADY_I && BRESP_O == ipf_pkg::RESP_OKAY);
    c_read_done: cover property (RVALID_O && RREADY_I && RRESP_O == ipf_pkg::RESP_OKAY);
    c_level7_irq: cover property (IRQ_O.valid && IRQ_O.level == ipf_pkg::LVL_MAX);
    c_unmapped: cover property (BVALID_O && BRESP_O == ipf_pkg::RESP_SLVERR);
    c_two_requests: cover property (IRQ_O.valid && IRQ_O.src == 5'h02 && $past(REQ_I[1]));

endmodule // ipf_bank

`default_nettype wire

// ### hw/ipf_bank_unused.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### tb/ipf_src_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Request sources: each pending line is registered and held as a level
// ------------------------------------------------------------
module ipf_src_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ipf_pkg::NUM_SRC-1:0] want_i,
    output logic [ipf_pkg::NUM_SRC-1:0] req_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_o <= '0;
        end else begin
            req_o <= want_i;
        end
    end
endmodule // ipf_src_model

`default_nettype wire

// ### tb/ipf_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none

module ipf_bank_tb;
    logic clk, rst, awv, wv, bry, arv, rry;
    logic [7:0] awa, ara;
    logic [31:0] wd, d;
    logic [3:0] ws;
    logic [1:0] r;
    logic [ipf_pkg::NUM_SRC-1:0] want, req;
    wire logic awr, wr_rdy, bv, arr, rv;
    wire logic [1:0] br, rr;
    wire logic [31:0] rdat;
    ipf_pkg::ipf_irq_t irq;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    // Implemented bits of each set; reset level 4 in every field
    logic [15:0] mask [6] = '{16'h7777, 16'h7777, 16'h7777, 16'h0777, 16'h7077, 16'h7777};
    int lsb [22] = '{12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 8, 4, 0, 12, 4, 0, 12, 8, 4, 0};

    ipf_bank #(.ADDR_W(8)) i_dut (
        .CLK_SYS_I(clk), .SYS_RST_I(rst),
        .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa),
        .WVALID_I(wv), .WREADY_O(wr_rdy), .WDATA_I(wd), .WSTRB_I(ws),
        .BVALID_O(bv), .BREADY_I(bry), .BRESP_O(br),
        .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara),
        .RVALID_O(rv), .RREADY_I(rry), .RDATA_O(rdat), .RRESP_O(rr),
        .REQ_I(req), .IRQ_O(irq)
    );

    ipf_src_model i_src (.clk_i(clk), .rst_i(rst), .want_i(want), .req_o(req));

    always #25 clk = ~clk;

    // ------------------------------------------------------------
    // Verdict and hang guard
    // ------------------------------------------------------------
    task automatic wrap_up;
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ------------------------------------------------------------
    // Bus tasks: handshakes sampled at the rising edge
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        @(posedge clk);
        awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= v; ws <= s; bry <= 1'b1;
        forever begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_rdy) wv <= 1'b0;
            if (bv && bry) begin
                r = br;
                bry <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk);
        arv <= 1'b1; ara <= a; rry <= 1'b1;
        forever begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (rv && rry) begin
                d = rdat;
                r = rr;
                rry <= 1'b0;
                break;
            end
        end
    endtask

    task automatic fill(input logic [15:0] v);
        for (int i = 0; i < 6; i++) begin
            axi_wr(8'(i * 4), {16'hFFFF, v}, 4'hF);
            chk("bresp", 32'(r), 32'(ipf_pkg::RESP_OKAY));
            axi_rd(8'(i * 4));
            chk("rresp", 32'(r), 32'(ipf_pkg::RESP_OKAY));
            chk("readback", d, {16'h0000, v & mask[i]});
        end
    endtask

    task automatic irq_chk(input logic [21:0] w, input logic [8:0] exp);
        @(posedge clk);
        want <= w;
        repeat (3) @(posedge clk);
        chk("irq", 32'(irq), {23'h0, exp});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 0; rst = 1; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0;
        awa = 0; ara = 0; wd = 0; ws = 0; want = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        chk("idle handshake", 32'({awr, wr_rdy, arr, bv, rv}), 32'h0000_001C);
        for (int i = 0; i < 6; i++) begin
            axi_rd(8'(i * 4));
            chk("reset value", d, {16'h0000, mask[i] & 16'h4444});
        end
        axi_rd(8'h18);
        chk("unmapped rresp", 32'(r), 32'(ipf_pkg::RESP_SLVERR));
        chk("unmapped rdata", d, 32'h0000_0000);
        axi_wr(8'h18, 32'hFFFF_FFFF, 4'hF);
        chk("unmapped bresp", 32'(r), 32'(ipf_pkg::RESP_SLVERR));
        fill(16'hFFFF);
        fill(16'h0000);
        axi_wr(8'h00, 32'h0000_FFFF, 4'h2);
        axi_rd(8'h00);
        chk("upper lane only", d, 32'h0000_7700);
        fill(16'h7531);
        for (int s = 0; s < 22; s++) begin
            irq_chk(22'(1) << s, {1'b1, 3'((16'h7531 >> lsb[s]) & 16'h7), 5'(s)});
        end
        irq_chk('1, {1'b1, 3'h7, 5'h00});
        axi_wr(8'h00, 32'h0000_0000, 4'hF);
        irq_chk(22'h11, {1'b1, 3'h7, 5'h04});
        irq_chk(22'h01, 9'h000);
        axi_wr(8'h00, 32'h0000_0560, 4'hF);
        irq_chk(22'h06, {1'b1, 3'h6, 5'h02});
        axi_wr(8'h14, 32'h0000_0030, 4'h1);
        axi_rd(8'h14);
        chk("lower lane only", d, 32'h0000_7530);
        irq_chk(22'h20_0000, 9'h000);
        axi_wr(8'h10, 32'h0000_0020, 4'hF);
        irq_chk(22'h38000, {1'b1, 3'h2, 5'h10});
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        axi_rd(8'h10);
        chk("level after reset", d, 32'h0000_4044);
        irq_chk(22'h38000, {1'b1, 3'h4, 5'h0F});
        wrap_up();
    end
endmodule // ipf_bank_tb

`default_nettype wire
